// [design/masx_defines.vh]
// Constants for the subtract, xor, swap and stop execution datapath
`ifndef MASX_DEFINES_VH
`define MASX_DEFINES_VH
// Opcode select codes
`define MASX_OP_NOP       4'h0
`define MASX_OP_SUBLIT    4'h1
`define MASX_OP_SUBREG    4'h2
`define MASX_OP_SUBBOR    4'h3
`define MASX_OP_SWAP      4'h4
`define MASX_OP_DIRLOAD   4'h5
`define MASX_OP_XORLIT    4'h6
`define MASX_OP_XORREG    4'h7
`define MASX_OP_STOP      4'h8
// Direction-load operand values
`define MASX_DIR_PORT_A   3'h5
`define MASX_DIR_PORT_B   3'h6
`define MASX_DIR_PORT_C   3'h7
// Register offsets (byte addresses)
`define MASX_REG_CTRL     4'h0
`define MASX_REG_OPERAND  4'h4
`define MASX_REG_ACCUM    4'h8
`define MASX_REG_STATUS   4'hC
`define MASX_REG_RESULT   5'h10
`define MASX_REG_DIR_A    5'h14
`define MASX_REG_DIR_B    5'h18
`define MASX_REG_DIR_C    5'h1C
`define MASX_REG_WDT      6'h20
// Control register fields
`define MASX_CTRL_OP_LSB  0
`define MASX_CTRL_DEST    4
`define MASX_CTRL_ARG_LSB 8
// Status register fields
`define MASX_ST_CARRY     0
`define MASX_ST_NIBBLE    1
`define MASX_ST_ZERO      2
`define MASX_ST_PDN       3
`define MASX_ST_TON       4
`define MASX_ST_STOPPED   5
// Reset values
`define MASX_ACC_RST      8'h00
`define MASX_STATUS_RST   5'h18
`define MASX_DIR_RST      8'hFF
`define MASX_WDT_RST      8'h00
`define MASX_PRE_RST      8'h00
`endif

// [design/masx_subtractor.v]
// Eight-bit subtractor with borrow in, carry and nibble carry out
`timescale 1ns/100ps
`include "masx_defines.vh"
module masx_subtractor (
	input  wire [7:0] minuend_i,
	input  wire [7:0] subtrahend_i,
	input  wire       carry_in_i,
	output wire [7:0] diff_o,
	output wire       carry_o,
	output wire       nibble_carry_o
);
	wire [4:0] low_sum;
	wire [4:0] high_sum;

	// Two's complement: a + ~b + carry; carry set means no borrow
	assign low_sum        = {1'b0, minuend_i[3:0]} + {1'b0, ~subtrahend_i[3:0]}
		+ {4'h0, carry_in_i};
	assign high_sum       = {1'b0, minuend_i[7:4]} + {1'b0, ~subtrahend_i[7:4]}
		+ {4'h0, low_sum[4]};
	assign diff_o         = {high_sum[3:0], low_sum[3:0]};
	assign carry_o        = high_sum[4];
	assign nibble_carry_o = low_sum[4];
endmodule

// [design/masx_power_ctl.v]
// Stop state and watchdog clear logic
`timescale 1ns/100ps
`include "masx_defines.vh"
module masx_power_ctl (
	input  wire       clk_i,
	input  wire       rstn_i,
	input  wire       stop_i,
	input  wire       wake_i,
	output reg  [7:0] watchdog_counter_o,
	output reg  [7:0] prescaler_o,
	output reg        stopped_o,
	output wire       osc_run_o
);
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			watchdog_counter_o <= `MASX_WDT_RST;
			prescaler_o        <= `MASX_PRE_RST;
			stopped_o          <= 1'b0;
		end else if (stop_i) begin
			watchdog_counter_o <= 8'h00; // RULE3
			prescaler_o        <= 8'h00; // RULE3
			stopped_o          <= 1'b1; // RULE3
		end else begin
			if (wake_i)
				stopped_o <= 1'b0;
			// Watchdog ticks only while the oscillator runs
			if (!stopped_o) begin
				prescaler_o <= prescaler_o + 8'h01;
				if (prescaler_o == 8'hFF)
					watchdog_counter_o <= watchdog_counter_o + 8'h01;
			end
		end
	end

	assign osc_run_o = ~stopped_o; // RULE3
endmodule

// [design/masx_alu.v]
// Execution datapath for subtract, xor, swap, direction load and stop
//
// Function
// [RULE1] Subtract-from-literal writes literal minus accumulator to the accumulator and updates carry, nibble carry and zero.
// [RULE2] Subtract-from-literal clears carry when accumulator exceeds literal, and nibble carry likewise on low nibbles.
// [RULE3] Stop clears the watchdog counter and prescaler, halts the oscillator and enters the stop state.
// [RULE4] Stop clears the powerdown flag, sets the timeout flag and leaves other status bits alone.
// [RULE5] Subtract-from-register computes register minus accumulator and routes it by the destination bit.
// [RULE6] Subtract-from-register sets carry when accumulator is at most the register, nibble carry likewise.
// [RULE7] Subtract-with-borrow also subtracts the inverted carry, routes by destination and updates three flags.
// [RULE8] Nibble swap exchanges the register halves, routes by destination and touches no flag.
// [RULE9] Direction load takes operands 5 to 7 only and copies the accumulator to port A, B or C direction.
// [RULE10] Xor with literal writes accumulator xor literal to the accumulator and updates only zero.
// [RULE11] Xor with register routes accumulator xor register by destination and updates only zero.
// [RULE12] The zero flag is set when an affecting result is zero and cleared otherwise.
//
// Local design decisions: the Avalon-MM register port and the register addresses.
`timescale 1ns/100ps
`include "masx_defines.vh"
module masx_alu (
	input  wire        clk_i,
	input  wire        rstn_i,
	// Avalon-MM slave
	input  wire [5:0]  avs_address_i,
	input  wire        avs_read_i,
	input  wire        avs_write_i,
	input  wire [31:0] avs_writedata_i,
	input  wire [3:0]  avs_byteenable_i,
	output reg  [31:0] avs_readdata_o,
	output wire        avs_waitrequest_o,
	// Wake input and datapath outputs
	input  wire        wake_i,
	output wire [7:0]  accum_o,
	output reg  [7:0]  file_result_o,
	output reg         file_write_o,
	output wire [7:0]  port_a_direction_reg_o,
	output wire [7:0]  port_b_direction_reg_o,
	output wire [7:0]  port_c_direction_reg_o,
	output wire        carry_flag_o,
	output wire        nibble_borrow_flag_o,
	output wire        zero_flag_o,
	output wire        timeout_flag_n_o,
	output wire        powerdown_flag_n_o,
	output wire        osc_run_o,
	output wire [7:0]  watchdog_counter_o
);
	reg  [7:0]  accum_q;
	reg  [7:0]  accum_d;
	reg  [7:0]  operand_q;
	reg  [7:0]  result_q;
	reg  [4:0]  status_q;
	reg  [4:0]  status_d;
	reg  [7:0]  dir_q [0:2];
	reg  [1:0]  dir_sel;
	reg         dir_we;
	reg  [7:0]  result_d;
	reg         file_we_d;
	reg         rd_ack_q;
	reg         illegal_q;
	reg         illegal_d;

	wire        wr_req;
	wire        rd_req;
	wire        ctrl_wr;
	wire [3:0]  op;
	wire        dest;
	wire [2:0]  dir_arg;
	wire [7:0]  sub_min;
	wire        sub_cin;
	wire [7:0]  sub_diff;
	wire        sub_carry;
	wire        sub_nib;
	wire [7:0]  wdt_cnt;
	wire [7:0]  wdt_pre;
	wire        stopped;
	wire        stop_exec;

	// Writes finish in the cycle they appear; reads take one wait cycle
	assign wr_req            = avs_write_i;
	assign rd_req            = avs_read_i & ~rd_ack_q;
	assign avs_waitrequest_o = rd_req;

	assign ctrl_wr = wr_req && avs_address_i == {2'b00, `MASX_REG_CTRL}
		&& avs_byteenable_i[0];
	assign op      = avs_writedata_i[`MASX_CTRL_OP_LSB +: 4];
	assign dest    = avs_writedata_i[`MASX_CTRL_DEST];
	assign dir_arg = avs_writedata_i[`MASX_CTRL_ARG_LSB +: 3];

	assign sub_min = (op == `MASX_OP_SUBLIT) ? operand_q : operand_q;
	// Literal subtract has no borrow in; borrow form uses carry
	assign sub_cin = (op == `MASX_OP_SUBBOR) ?
		status_q[`MASX_ST_CARRY] : 1'b1; // RULE7

	masx_subtractor u_sub (
		.minuend_i      (sub_min),
		.subtrahend_i   (accum_q),
		.carry_in_i     (sub_cin),
		.diff_o         (sub_diff),
		.carry_o        (sub_carry),
		.nibble_carry_o (sub_nib)
	);

	assign stop_exec = ctrl_wr && op == `MASX_OP_STOP;

	masx_power_ctl u_pwr (
		.clk_i              (clk_i),
		.rstn_i             (rstn_i),
		.stop_i             (stop_exec),
		.wake_i             (wake_i),
		.watchdog_counter_o (wdt_cnt),
		.prescaler_o        (wdt_pre),
		.stopped_o          (stopped),
		.osc_run_o          (osc_run_o)
	);

	// Routes a result by destination bit
	task route;
		input [7:0] val;
		begin
			result_d = val;
			if (dest)
				file_we_d = 1'b1;
			else
				accum_d = val;
		end
	endtask

	always @* begin
		accum_d   = accum_q;
		status_d  = status_q;
		result_d  = result_q;
		file_we_d = 1'b0;
		dir_we    = 1'b0;
		dir_sel   = 2'd0;
		illegal_d = 1'b0;
		if (ctrl_wr) begin
			case (op)
			`MASX_OP_SUBLIT: begin
				accum_d  = sub_diff; // RULE1
				result_d = sub_diff;
				status_d[`MASX_ST_CARRY]  = sub_carry; // RULE2
				status_d[`MASX_ST_NIBBLE] = sub_nib; // RULE2
				status_d[`MASX_ST_ZERO]   = sub_diff == 8'h00; // RULE12
			end
			`MASX_OP_SUBREG: begin
				route(sub_diff); // RULE5
				status_d[`MASX_ST_CARRY]  = sub_carry; // RULE6
				status_d[`MASX_ST_NIBBLE] = sub_nib; // RULE6
				status_d[`MASX_ST_ZERO]   = sub_diff == 8'h00; // RULE12
			end
			`MASX_OP_SUBBOR: begin
				route(sub_diff); // RULE7
				status_d[`MASX_ST_CARRY]  = sub_carry; // RULE7
				status_d[`MASX_ST_NIBBLE] = sub_nib; // RULE7
				status_d[`MASX_ST_ZERO]   = sub_diff == 8'h00; // RULE12
			end
			`MASX_OP_SWAP: begin
				route({operand_q[3:0], operand_q[7:4]}); // RULE8
			end
			`MASX_OP_DIRLOAD: begin
				// Operands outside 5..7 are dropped and flagged
				if (dir_arg >= `MASX_DIR_PORT_A) begin
					dir_we  = 1'b1; // RULE9
					dir_sel = dir_arg[1:0] - 2'd1;
				end else begin
					illegal_d = 1'b1;
				end
			end
			`MASX_OP_XORLIT: begin
				accum_d  = accum_q ^ operand_q; // RULE10
				result_d = accum_q ^ operand_q;
				status_d[`MASX_ST_ZERO] =
					(accum_q ^ operand_q) == 8'h00; // RULE12
			end
			`MASX_OP_XORREG: begin
				route(accum_q ^ operand_q); // RULE11
				status_d[`MASX_ST_ZERO] =
					(accum_q ^ operand_q) == 8'h00; // RULE12
			end
			`MASX_OP_STOP: begin
				status_d[`MASX_ST_PDN] = 1'b0; // RULE4
				status_d[`MASX_ST_TON] = 1'b1; // RULE4
			end
			default: begin
				illegal_d = 1'b0;
			end
			endcase
		end else if (wr_req && avs_byteenable_i[0]) begin
			if (avs_address_i == {2'b00, `MASX_REG_ACCUM})
				accum_d = avs_writedata_i[7:0];
			if (avs_address_i == {2'b00, `MASX_REG_STATUS})
				status_d[2:0] = avs_writedata_i[2:0];
		end
	end

	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			accum_q       <= `MASX_ACC_RST;
			operand_q     <= 8'h00;
			result_q      <= 8'h00;
			status_q      <= `MASX_STATUS_RST;
			file_result_o <= 8'h00;
			file_write_o  <= 1'b0;
			rd_ack_q      <= 1'b0;
			illegal_q     <= 1'b0;
		end else begin
			accum_q       <= accum_d;
			status_q      <= status_d;
			result_q      <= result_d;
			file_result_o <= result_d;
			file_write_o  <= file_we_d;
			rd_ack_q      <= rd_req;
			if (illegal_d)
				illegal_q <= 1'b1;
			else if (rd_req && avs_address_i == {2'b00, `MASX_REG_CTRL})
				illegal_q <= 1'b0;
			if (wr_req && avs_byteenable_i[0]
				&& avs_address_i == {2'b00, `MASX_REG_OPERAND})
				operand_q <= avs_writedata_i[7:0];
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_dir
			always @(posedge clk_i or negedge rstn_i) begin
				if (!rstn_i)
					dir_q[gi] <= `MASX_DIR_RST;
				else if (dir_we && {30'h0, dir_sel} == gi)
					dir_q[gi] <= accum_q; // RULE9
			end
		end
	endgenerate

	// Read data registered at the wait cycle
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			avs_readdata_o <= 32'h0000_0000;
		end else if (rd_req) begin
			case (avs_address_i)
			{2'b00, `MASX_REG_CTRL}:    avs_readdata_o <= {31'h0, illegal_q};
			{2'b00, `MASX_REG_OPERAND}: avs_readdata_o <= {24'h0, operand_q};
			{2'b00, `MASX_REG_ACCUM}:   avs_readdata_o <= {24'h0, accum_q};
			{2'b00, `MASX_REG_STATUS}:
				avs_readdata_o <= {26'h0, stopped, status_q};
			{1'b0, `MASX_REG_RESULT}:   avs_readdata_o <= {24'h0, result_q};
			{1'b0, `MASX_REG_DIR_A}:    avs_readdata_o <= {24'h0, dir_q[0]};
			{1'b0, `MASX_REG_DIR_B}:    avs_readdata_o <= {24'h0, dir_q[1]};
			{1'b0, `MASX_REG_DIR_C}:    avs_readdata_o <= {24'h0, dir_q[2]};
			`MASX_REG_WDT:
				avs_readdata_o <= {16'h0, wdt_pre, wdt_cnt};
			default: avs_readdata_o <= 32'h0000_0000;
			endcase
		end
	end

	assign accum_o                = accum_q;
	assign port_a_direction_reg_o = dir_q[0];
	assign port_b_direction_reg_o = dir_q[1];
	assign port_c_direction_reg_o = dir_q[2];
	assign carry_flag_o           = status_q[`MASX_ST_CARRY];
	assign nibble_borrow_flag_o   = status_q[`MASX_ST_NIBBLE];
	assign zero_flag_o            = status_q[`MASX_ST_ZERO];
	assign powerdown_flag_n_o     = status_q[`MASX_ST_PDN];
	assign timeout_flag_n_o       = status_q[`MASX_ST_TON];
	assign watchdog_counter_o     = wdt_cnt;
endmodule

// [tb/masx_alu_asserts.sv]
// Port-level checks for the subtract, xor, swap and stop datapath
`timescale 1ns/100ps
module masx_alu_chk (
	input wire        clk_i,
	input wire        rstn_i,
	input wire [5:0]  avs_address_i,
	input wire        avs_write_i,
	input wire [31:0] avs_writedata_i,
	input wire [3:0]  avs_byteenable_i,
	input wire [7:0]  accum_o,
	input wire        file_write_o,
	input wire [7:0]  port_a_direction_reg_o,
	input wire [7:0]  port_b_direction_reg_o,
	input wire [7:0]  port_c_direction_reg_o,
	input wire        carry_flag_o,
	input wire        nibble_borrow_flag_o,
	input wire        zero_flag_o,
	input wire        timeout_flag_n_o,
	input wire        powerdown_flag_n_o,
	input wire        osc_run_o,
	input wire [7:0]  watchdog_counter_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	// Writes to the control word execute; writes never wait
	wire       ex = avs_write_i && avs_address_i == 6'h00 && avs_byteenable_i[0];
	wire [3:0] op = avs_writedata_i[3:0];
	wire [2:0] arg = avs_writedata_i[10:8];
	wire       fop = op == 4'h2 || op == 4'h3 || op == 4'h4 || op == 4'h7;
	sequence s_cz_kept;
		$stable(carry_flag_o) && $stable(nibble_borrow_flag_o);
	endsequence
	sequence s_all_kept;
		s_cz_kept ##0 $stable(zero_flag_o);
	endsequence
	property p_stop;
		ex && op == 4'h8 |=> !powerdown_flag_n_o && timeout_flag_n_o
			&& !osc_run_o && watchdog_counter_o == 8'h00;
	endproperty
	a_stop: assert property (p_stop)
		else $error("stop outputs wrong");
	property p_stop_flags;
		ex && op == 4'h8 |=> s_all_kept;
	endproperty
	a_stop_flags: assert property (p_stop_flags)
		else $error("stop touched flags");
	property p_swap_flags;
		ex && op == 4'h4 |=> s_all_kept;
	endproperty
	a_swap_flags: assert property (p_swap_flags)
		else $error("swap touched flags");
	property p_xor_cy;
		ex && (op == 4'h6 || op == 4'h7) |=> s_cz_kept;
	endproperty
	a_xor_cy: assert property (p_xor_cy)
		else $error("xor touched carry");
	property p_zero_w;
		ex && (op == 4'h1 || op == 4'h6) |=> zero_flag_o == (accum_o == 8'h00);
	endproperty
	a_zero_w: assert property (p_zero_w)
		else $error("zero flag wrong");
	property p_route;
		ex && fop |=> file_write_o == $past(avs_writedata_i[4]);
	endproperty
	a_route: assert property (p_route)
		else $error("destination wrong");
	property p_dir_a;
		ex && op == 4'h5 && arg == 3'h5 |=> $stable(port_b_direction_reg_o)
			&& port_a_direction_reg_o == $past(accum_o);
	endproperty
	a_dir_a: assert property (p_dir_a)
		else $error("port a direction wrong");
	property p_dir_bad;
		ex && op == 4'h5 && arg < 3'h5 |=> $stable(port_a_direction_reg_o)
			&& $stable(port_b_direction_reg_o)
			&& $stable(port_c_direction_reg_o);
	endproperty
	a_dir_bad: assert property (p_dir_bad)
		else $error("bad operand loaded");
endmodule

// [tb/test_masx_alu.sv]
// Self-checking bench for the subtract, xor, swap and stop datapath
`timescale 1ns/100ps
`include "masx_defines.vh"
module test_masx_alu;
	reg         clk_i = 1'b0;
	reg         rstn_i = 1'b0;
	reg  [5:0]  avs_address_i = 6'h00;
	reg         avs_read_i = 1'b0;
	reg         avs_write_i = 1'b0;
	reg  [31:0] avs_writedata_i = 32'h00000000;
	reg  [3:0]  avs_byteenable_i = 4'hF;
	reg         wake_i = 1'b0;
	wire [31:0] avs_readdata_o;
	wire        avs_waitrequest_o;
	wire [7:0]  accum_o;
	wire [7:0]  file_result_o;
	wire        file_write_o;
	wire [7:0]  port_a_direction_reg_o;
	wire [7:0]  port_b_direction_reg_o;
	wire [7:0]  port_c_direction_reg_o;
	wire        carry_flag_o;
	wire        nibble_borrow_flag_o;
	wire        zero_flag_o;
	wire        timeout_flag_n_o;
	wire        powerdown_flag_n_o;
	wire        osc_run_o;
	wire [7:0]  watchdog_counter_o;
	wire [2:0]  flags = {zero_flag_o, nibble_borrow_flag_o, carry_flag_o};
	wire [23:0] dirs = {port_a_direction_reg_o, port_b_direction_reg_o,
		port_c_direction_reg_o};
	integer     fail_count = 0;
	integer     checks = 0;
	reg  [31:0] q;

	always #20 clk_i = ~clk_i;

	masx_alu dut_u (.*);

	task summarize;
		begin
			$display("checks %0d fail_count %0d", checks, fail_count);
			if (fail_count == 0 && checks > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask

	task chk(input [31:0] seen, input [31:0] exp);
		begin
			checks = checks + 1;
			if (seen !== exp) begin
				fail_count = fail_count + 1;
				$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
			end
		end
	endtask

	// One idle edge before each request keeps drives one per time step
	task bus(input rd, input [5:0] a, input [31:0] d);
		integer n;
		begin
			@(posedge clk_i);
			avs_address_i <= a;
			avs_writedata_i <= d;
			avs_read_i <= rd;
			avs_write_i <= !rd;
			n = 0;
			@(posedge clk_i);
			while (avs_waitrequest_o !== 1'b0 && n < 20) begin
				n = n + 1;
				@(posedge clk_i);
			end
			if (n >= 20) begin
				fail_count = fail_count + 1;
				summarize;
			end
			q = avs_readdata_o;
			avs_read_i <= 1'b0;
			avs_write_i <= 1'b0;
			#1;
		end
	endtask

	task ex(input [3:0] op, input d, input [2:0] arg);
		bus(0, `MASX_REG_CTRL, {21'h0, arg, 3'h0, d, op});
	endtask

	task run(input [3:0] op, input d, input [2:0] st, input [7:0] wv,
		input [7:0] fv, input [7:0] r, input [2:0] fl);
		begin
			bus(0, `MASX_REG_STATUS, {29'h0, st});
			bus(0, `MASX_REG_ACCUM, {24'h0, wv});
			bus(0, `MASX_REG_OPERAND, {24'h0, fv});
			ex(op, d, 3'h0);
			chk(file_write_o, d);
			chk(d ? file_result_o : accum_o, r);
			chk(accum_o, d ? wv : r);
			chk(flags, fl);
		end
	endtask

	task t_reset;
		begin
			chk(dirs, 24'hFFFFFF);
			bus(1, `MASX_REG_STATUS, 32'h0);
			chk(q, 32'h00000018);
			bus(1, 6'h24, 32'h0);
			chk(q, 32'h00000000);
		end
	endtask

	// Equal operands, borrow on each nibble, and borrow-in both ways
	task t_sub;
		begin
			run(4'h1, 0, 3'h0, 8'h05, 8'h05, 8'h00, 3'h7);
			run(4'h1, 0, 3'h0, 8'h06, 8'h05, 8'hFF, 3'h0);
			run(4'h1, 0, 3'h0, 8'h1F, 8'h20, 8'h01, 3'h1);
			run(4'h2, 1, 3'h0, 8'h80, 8'h7F, 8'hFF, 3'h2);
			run(4'h2, 0, 3'h0, 8'h10, 8'h10, 8'h00, 3'h7);
			run(4'h3, 0, 3'h0, 8'h00, 8'h00, 8'hFF, 3'h0);
			run(4'h3, 1, 3'h1, 8'h01, 8'h01, 8'h00, 3'h7);
			run(4'h3, 0, 3'h1, 8'h0F, 8'h1F, 8'h10, 3'h3);
		end
	endtask

	task t_logic;
		begin
			run(4'h4, 0, 3'h7, 8'h3C, 8'hA5, 8'h5A, 3'h7);
			run(4'h4, 1, 3'h2, 8'h3C, 8'hA5, 8'h5A, 3'h2);
			run(4'h6, 0, 3'h3, 8'hF0, 8'hF0, 8'h00, 3'h7);
			run(4'h6, 0, 3'h4, 8'h0F, 8'hF0, 8'hFF, 3'h0);
			run(4'h7, 1, 3'h5, 8'h55, 8'hAA, 8'hFF, 3'h1);
			run(4'h7, 0, 3'h2, 8'h33, 8'h33, 8'h00, 3'h6);
		end
	endtask

	task t_dir;
		begin
			bus(0, `MASX_REG_STATUS, 32'h5);
			bus(0, `MASX_REG_ACCUM, 32'h3A);
			ex(4'h5, 0, 3'h5);
			bus(0, `MASX_REG_ACCUM, 32'h4B);
			ex(4'h5, 0, 3'h6);
			bus(0, `MASX_REG_ACCUM, 32'h5C);
			ex(4'h5, 0, 3'h7);
			chk(dirs, 24'h3A4B5C);
			bus(0, `MASX_REG_ACCUM, 32'h77);
			ex(4'h5, 0, 3'h4);
			chk(dirs, 24'h3A4B5C);
			chk(flags, 3'h5);
			bus(1, `MASX_REG_CTRL, 32'h0);
			chk(q[0], 1'b1);
			bus(1, `MASX_REG_CTRL, 32'h0);
			chk(q[0], 1'b0);
		end
	endtask

	// Let the prescaler wrap once, so both clears are visible
	task t_stop;
		begin
			bus(0, `MASX_REG_STATUS, 32'h6);
			repeat (256) @(posedge clk_i);
			bus(1, `MASX_REG_WDT, 32'h0);
			chk(q[15:8] != 8'h00, 1'b1);
			chk(q[7:0] != 8'h00, 1'b1);
			ex(4'h8, 0, 3'h0);
			chk({osc_run_o, powerdown_flag_n_o, timeout_flag_n_o}, 3'h1);
			chk(watchdog_counter_o, 8'h00);
			chk(flags, 3'h6);
			bus(1, `MASX_REG_WDT, 32'h0);
			chk(q, 32'h00000000);
			bus(1, `MASX_REG_STATUS, 32'h0);
			chk(q, 32'h00000036);
			@(posedge clk_i);
			wake_i <= 1'b1;
			@(posedge clk_i);
			wake_i <= 1'b0;
			#1;
			chk(osc_run_o, 1'b1);
		end
	endtask

	initial begin
		repeat (6) @(posedge clk_i);
		rstn_i <= 1'b1;
		t_reset;
		t_sub;
		t_logic;
		t_dir;
		t_stop;
		summarize;
	end
endmodule

bind masx_alu masx_alu_chk chk_u (.*);
